//--- shared/tkbc_pkg.sv
/*
  constants and types shared by the touch key burst control block.
  assumes a single 250 MHz clock; all timing counts derive from the clock period.
*/
package tkbc_pkg;

  // run modes chosen by the mode/trigger pin
  typedef enum logic [1:0] {
    TKBC_FAST,
    TKBC_LOW_POWER,
    TKBC_TRIGGERED
  } tkbc_mode_e;

  localparam int CLK_PERIOD_NS = 4;

  // times as specified, in their own units
  localparam int FAST_GAP_US = 1000;
  localparam int LP_SLEEP_US = 80000;
  localparam int POWERUP_US = 100000;
  localparam int HEALTH_NS = 15000;
  localparam int MIN_PULSE_NS = 10000;
  localparam int SHORT_WIN_US = 1000;

  // least times round up to whole cycles
  localparam int FAST_GAP_CYC = (FAST_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LP_SLEEP_CYC = (LP_SLEEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HEALTH_CYC = (HEALTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_WIN_CYC = (SHORT_WIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TIMER_W = 25;
  localparam int MEAS_W = 12;

  // signal processing figures, in measurement counts
  localparam int THRESH = 10;
  localparam int HYST = 2;
  localparam int DI_LIMIT = 4;
  localparam int NEG_DRIFT_DIV = 2;
  localparam int POS_DRIFT_DIV = 16;
  localparam int RECAL_MEAS = 64;

  // spread spectrum swing in tenths of a percent, and dwell per step
  localparam int SPREAD_PERMILLE = 75;
  localparam int SPREAD_STEP_CYC = 4;
  localparam logic [7:0] TRIM_ZERO = 8'h00;

endpackage

//--- rtl/tkbc_sync.sv
/*
  two flip-flop synchroniser for one asynchronous level.
  assumes the input is a pin with no relation to clock.
*/
module tkbc_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;
  logic meta_next;
  logic sync_next;

  // the first stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    if (!reset_n) begin
      meta_next = 1'b0;
      sync_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    meta_reg <= meta_next;
    sync_out <= sync_next;
  end

endmodule

//--- rtl/tkbc_spread.sv
/*
  triangle modulator for the burst oscillator trim, in signed tenths of a percent.
  assumes burst_active stays high for the whole measurement burst.
*/
module tkbc_spread #(
  parameter int SWING = tkbc_pkg::SPREAD_PERMILLE,
  parameter int STEP_CYC = tkbc_pkg::SPREAD_STEP_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic burst_active,
  output logic [7:0] trim_reg
);

  localparam logic [7:0] SWING_POS = 8'(SWING);
  localparam logic [7:0] SWING_NEG = 8'(-SWING);

  logic [7:0] trim_next;
  logic up_reg;
  logic up_next;
  logic [7:0] dwell_reg;
  logic [7:0] dwell_next;

  // sweep between both limits; idle returns to nominal so sleep draws no offset
  always_comb begin
    trim_next = trim_reg;
    up_next = up_reg;
    dwell_next = dwell_reg;
    if (!reset_n || !burst_active) begin
      trim_next = tkbc_pkg::TRIM_ZERO;
      up_next = 1'b1;
      dwell_next = 8'h00;
    end else if (dwell_reg != 8'(STEP_CYC - 1)) begin
      dwell_next = dwell_reg + 8'h01;
    end else begin
      dwell_next = 8'h00;
      if (up_reg) begin
        trim_next = trim_reg + 8'h01;
        if (trim_reg + 8'h01 == SWING_POS) up_next = 1'b0;
      end else begin
        trim_next = trim_reg - 8'h01;
        if (trim_reg - 8'h01 == SWING_NEG) up_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    trim_reg <= trim_next;
    up_reg <= up_next;
    dwell_reg <= dwell_next;
  end

endmodule

//--- rtl/tkbc_top.sv
/*
  burst sequencer and detection logic for one capacitive touch key.
  assumes an analog front end that measures one burst per burst_req and
  returns meas_count with a one-cycle meas_valid; the pin is asynchronous.
*/
module tkbc_top #(
  parameter int FAST_GAP_CYC = tkbc_pkg::FAST_GAP_CYC,
  parameter int LP_SLEEP_CYC = tkbc_pkg::LP_SLEEP_CYC,
  parameter int POWERUP_CYC = tkbc_pkg::POWERUP_CYC,
  parameter int SHORT_WIN_CYC = tkbc_pkg::SHORT_WIN_CYC,
  parameter int RECAL_MEAS = tkbc_pkg::RECAL_MEAS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic mode_trigger_pin,
  input wire logic meas_valid,
  input wire logic [tkbc_pkg::MEAS_W-1:0] meas_count,
  output logic burst_req,
  output logic detect_out,
  output logic detect_oe,
  output logic output_valid,
  output logic [1:0] run_mode,
  output logic [7:0] osc_trim
);

  localparam int TW = tkbc_pkg::TIMER_W;
  localparam int DW = tkbc_pkg::MEAS_W + 1;

  typedef enum logic [1:0] {
    TKBC_ST_GAP,
    TKBC_ST_HEALTH,
    TKBC_ST_BURST
  } tkbc_state_e;

  // signed difference of two measurement values
  function automatic logic signed [DW-1:0] tkbc_diff(input logic [DW-2:0] a,
                                                     input logic [DW-2:0] b);
    tkbc_diff = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction

  logic pin_sync;
  logic pin_prev_reg, pin_prev_next;
  tkbc_state_e state_reg, state_next;
  tkbc_pkg::tkbc_mode_e mode_reg, mode_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic [TW-1:0] idle_reg, idle_next;
  logic [TW-1:0] high_reg, high_next;
  logic rise_pend_reg, rise_pend_next;
  logic wake_reg, wake_next;
  logic [TW-1:0] pwr_reg, pwr_next;
  logic calib_reg, calib_next;
  logic [DW-2:0] ref_reg, ref_next;
  logic [2:0] integ_reg, integ_next;
  logic active_reg, active_next;
  logic [4:0] neg_reg, neg_next;
  logic [4:0] pos_reg, pos_next;
  logic [7:0] recal_reg, recal_next;
  logic burst_req_next, detect_out_next, detect_oe_next, output_valid_next;
  logic [1:0] run_mode_next;
  logic signed [DW-1:0] delta;
  logic hit;
  logic [TW-1:0] gap_len;

  tkbc_sync u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(mode_trigger_pin),
    .sync_out(pin_sync)
  );

  // trim runs only while the front end is measuring
  tkbc_spread u_spread (
    .clock(clock),
    .reset_n(reset_n),
    .burst_active(state_reg == TKBC_ST_BURST),
    .trim_reg(osc_trim)
  );

  assign delta = tkbc_diff(meas_count, ref_reg);
  assign hit = delta >= DW'(tkbc_pkg::THRESH);

  // low-power spacing falls back to fast while the integrator is part-way
  always_comb begin
    if (mode_reg == tkbc_pkg::TKBC_LOW_POWER && integ_reg == 3'h0) begin
      gap_len = TW'(LP_SLEEP_CYC);
    end else begin
      gap_len = TW'(FAST_GAP_CYC);
    end
  end

  // sequencer, trigger edge handling and signal processing
  always_comb begin
    pin_prev_next = pin_sync;
    state_next = state_reg;
    mode_next = mode_reg;
    timer_next = timer_reg;
    idle_next = idle_reg;
    high_next = high_reg;
    rise_pend_next = rise_pend_reg;
    wake_next = 1'b0;
    pwr_next = pwr_reg;
    calib_next = calib_reg;
    ref_next = ref_reg;
    integ_next = integ_reg;
    active_next = active_reg;
    neg_next = neg_reg;
    pos_next = pos_reg;
    recal_next = recal_reg;
    burst_req_next = 1'b0;
    detect_oe_next = 1'b1;
    output_valid_next = output_valid;

    // power-up hold-off before the output means anything
    if (pwr_reg != TW'(POWERUP_CYC)) begin
      pwr_next = pwr_reg + TW'(1);
    end else begin
      output_valid_next = 1'b1;
    end

    // triggered mode edge watch; a short high pulse bursts only on its fall
    if (mode_reg == tkbc_pkg::TKBC_TRIGGERED) begin
      if (pin_sync != pin_prev_reg) begin
        idle_next = '0;
      end else if (idle_reg != TW'(LP_SLEEP_CYC)) begin
        idle_next = idle_reg + TW'(1);
      end
      if (pin_sync && !pin_prev_reg) begin
        rise_pend_next = 1'b1;
        high_next = '0;
      end else if (pin_sync && rise_pend_reg) begin
        high_next = high_reg + TW'(1);
        if (high_reg == TW'(SHORT_WIN_CYC - 1)) begin
          rise_pend_next = 1'b0; // long high: wakes once the short window has passed, before the fall
          wake_next = 1'b1;
        end
      end else if (!pin_sync && pin_prev_reg) begin
        rise_pend_next = 1'b0;
        // glitches under the minimum width are ignored
        if (!rise_pend_reg || high_reg >= TW'(tkbc_pkg::MIN_PULSE_CYC)) begin
          wake_next = 1'b1;
        end
      end
    end else begin
      idle_next = '0;
      rise_pend_next = 1'b0;
      high_next = '0;
    end

    case (state_reg)
      TKBC_ST_GAP: begin
        if (mode_reg == tkbc_pkg::TKBC_TRIGGERED) begin
          if (wake_reg) begin
            state_next = TKBC_ST_HEALTH;
            timer_next = '0;
          end else if (idle_reg == TW'(LP_SLEEP_CYC)) begin
            // quiet pin: back to free running, chosen by level
            mode_next = pin_sync ? tkbc_pkg::TKBC_FAST : tkbc_pkg::TKBC_LOW_POWER;
            state_next = TKBC_ST_HEALTH;
            timer_next = '0;
          end
        end else if (timer_reg >= gap_len) begin
          state_next = TKBC_ST_HEALTH;
          timer_next = '0;
        end else begin
          timer_next = timer_reg + TW'(1);
        end
      end
      TKBC_ST_HEALTH: begin
        detect_oe_next = 1'b0;
        // pad stays released for the full HEALTH_CYC samples before the burst
        if (timer_reg == TW'(tkbc_pkg::HEALTH_CYC)) begin
          detect_oe_next = 1'b1;
          burst_req_next = 1'b1;
          state_next = TKBC_ST_BURST;
          timer_next = '0;
        end else begin
          timer_next = timer_reg + TW'(1);
        end
      end
      TKBC_ST_BURST: begin
        if (meas_valid) begin
          state_next = TKBC_ST_GAP;
          timer_next = '0;
          // pin level sets the mode only here or at the idle timeout in the gap, so modes never change mid-burst
          if (!pin_sync && mode_reg == tkbc_pkg::TKBC_FAST) begin
            mode_next = tkbc_pkg::TKBC_TRIGGERED;
          end else if (pin_sync && mode_reg == tkbc_pkg::TKBC_LOW_POWER) begin
            mode_next = tkbc_pkg::TKBC_FAST;
          end else begin
            mode_next = mode_reg;
          end
          if (!calib_reg) begin
            calib_next = 1'b1; // first burst sets the reference
            ref_next = meas_count;
          end else begin
            if (active_reg) begin
              // release only below threshold less hysteresis
              if (delta < DW'(tkbc_pkg::THRESH - tkbc_pkg::HYST)) begin
                active_next = 1'b0;
                integ_next = 3'h0;
              end
            end else if (hit && mode_reg == tkbc_pkg::TKBC_TRIGGERED) begin
              active_next = 1'b1;
              integ_next = 3'h0;
            end else if (hit) begin
              if (integ_reg == 3'(tkbc_pkg::DI_LIMIT - 1)) begin
                active_next = 1'b1;
                integ_next = 3'h0;
              end else begin
                integ_next = integ_reg + 3'h1;
              end
            end else begin
              integ_next = 3'h0;
            end
            // drift tracking frozen during a detection; falling side is quicker
            if (!active_reg && !hit) begin
              if (delta < 0) begin
                pos_next = '0;
                if (neg_reg == 5'(tkbc_pkg::NEG_DRIFT_DIV - 1)) begin
                  neg_next = '0;
                  ref_next = ref_reg - (DW - 1)'(1);
                end else begin
                  neg_next = neg_reg + 5'h01;
                end
              end else if (delta > 0) begin
                neg_next = '0;
                if (pos_reg == 5'(tkbc_pkg::POS_DRIFT_DIV - 1)) begin
                  pos_next = '0;
                  ref_next = ref_reg + (DW - 1)'(1);
                end else begin
                  pos_next = pos_reg + 5'h01;
                end
              end
            end
            // timeout counts strongly negative measurements, never detections
            if (delta <= -DW'(tkbc_pkg::THRESH)) begin
              if (recal_reg == 8'(RECAL_MEAS - 1)) begin
                recal_next = 8'h00;
                ref_next = meas_count;
              end else begin
                recal_next = recal_reg + 8'h01;
              end
            end else begin
              recal_next = 8'h00;
            end
          end
        end
      end
      default: begin
        state_next = TKBC_ST_GAP;
        timer_next = '0;
      end
    endcase

    detect_out_next = active_next && output_valid_next;
    run_mode_next = mode_next;

    if (!reset_n) begin
      pin_prev_next = 1'b0;
      state_next = TKBC_ST_GAP;
      mode_next = tkbc_pkg::TKBC_FAST;
      timer_next = '0;
      idle_next = '0;
      high_next = '0;
      rise_pend_next = 1'b0;
      wake_next = 1'b0;
      pwr_next = '0;
      calib_next = 1'b0;
      ref_next = '0;
      integ_next = 3'h0;
      active_next = 1'b0;
      neg_next = '0;
      pos_next = '0;
      recal_next = 8'h00;
      burst_req_next = 1'b0;
      detect_out_next = 1'b0;
      detect_oe_next = 1'b1;
      output_valid_next = 1'b0;
      run_mode_next = 2'h0;
    end
  end

  always_ff @(posedge clock) begin
    pin_prev_reg <= pin_prev_next;
    state_reg <= state_next;
    mode_reg <= mode_next;
    timer_reg <= timer_next;
    idle_reg <= idle_next;
    high_reg <= high_next;
    rise_pend_reg <= rise_pend_next;
    wake_reg <= wake_next;
    pwr_reg <= pwr_next;
    calib_reg <= calib_next;
    ref_reg <= ref_next;
    integ_reg <= integ_next;
    active_reg <= active_next;
    neg_reg <= neg_next;
    pos_reg <= pos_next;
    recal_reg <= recal_next;
    burst_req <= burst_req_next;
    detect_out <= detect_out_next;
    detect_oe <= detect_oe_next;
    output_valid <= output_valid_next;
    run_mode <= run_mode_next;
  end

endmodule

//--- bench/tkbc_chk.sv
/*
  port assertions for the touch key burst control block.
  assumes it is bound to the top module and handed its power-up count.
*/
module tkbc_chk #(
  parameter int POWERUP_CYC = 100
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic meas_valid,
  input wire logic burst_req,
  input wire logic detect_out,
  input wire logic detect_oe,
  input wire logic output_valid,
  input wire logic [1:0] run_mode,
  input wire logic [7:0] osc_trim
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] low_reg, low_next;
  logic [24:0] up_reg, up_next;

  // pad release time and time since reset; the second saturates so it never wraps
  always_comb begin
    low_next = detect_oe ? 13'h0 : low_reg + 13'h1;
    up_next = (up_reg == 25'h1FFFFFF) ? up_reg : up_reg + 25'h1;
    if (!reset_n) begin
      low_next = 13'h0;
      up_next = 25'h0;
    end
  end

  always_ff @(posedge clock) begin
    low_reg <= low_next;
    up_reg <= up_next;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_reset_quiet: assert property (disable iff (1'b0)
    !reset_n |=> !burst_req && detect_oe && !output_valid) else $error("outputs busy in reset");
  a_req_after_health: assert property (
    burst_req |-> detect_oe && !$past(detect_oe)) else $error("burst without health window");
  a_health_width: assert property (
    $rose(detect_oe) |-> low_reg == tkbc_pkg::HEALTH_CYC) else $error("health window length");
  a_mode_at_end: assert property (
    $changed(run_mode) |=> $past(meas_valid, 2) || !detect_oe)
    else $error("mode changed inside a burst");
  a_detect_valid: assert property (
    detect_out |-> output_valid) else $error("detect shown before output valid");
  a_detect_steady: assert property (
    $changed(detect_out) |-> $past(meas_valid) || $past(meas_valid, 2) || $rose(output_valid))
    else $error("detect changed without a measurement");
  a_trim_range: assert property (
    $signed(osc_trim) <= 8'sh4B && $signed(osc_trim) >= -8'sh4B) else $error("trim out of range");
  a_trim_quiet: assert property (
    !detect_oe |-> osc_trim == 8'h00) else $error("trim moving outside a burst");
  a_valid_time: assert property (
    $rose(output_valid) |-> up_reg >= POWERUP_CYC - 2 && up_reg <= POWERUP_CYC + 2)
    else $error("output valid at wrong time");

  c_detect: cover property ($rose(detect_out));
  c_trig: cover property (run_mode == 2'h2);
  c_low_power: cover property (run_mode == 2'h1);
endmodule

//--- bench/tkbc_fe_model.sv
/*
  behavioural front end: one result word for each burst request.
  assumes the bench sets the burst length before the request and the word before the burst ends.
*/
module tkbc_fe_model (
  input wire logic clock,
  input wire logic burst_req,
  input wire logic [15:0] burst_len,
  input wire logic [11:0] level,
  output logic meas_valid,
  output logic [11:0] meas_count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    meas_valid = 1'b0;
    meas_count = 12'hFFF;
  end

  // the word is inverted after the strobe so a late sample never sees a stale match
  always begin
    @(posedge clock);
    if (burst_req === 1'b1) begin
      repeat (burst_len) @(negedge clock);
      meas_valid = 1'b1;
      meas_count = level;
      @(negedge clock);
      meas_valid = 1'b0;
      meas_count = ~level;
    end
  end
endmodule

//--- bench/tkbc_tb.sv
/*
  self-checking bench for the touch key burst control block.
  assumes shortened counts; the front end model answers every burst.
*/
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 50;
  localparam int SLEEP = 4000;
  logic clock;
  logic reset_n;
  logic mode_trigger_pin;
  logic meas_valid;
  logic [11:0] meas_count;
  logic burst_req;
  logic detect_out;
  logic detect_oe;
  logic output_valid;
  logic [1:0] run_mode;
  logic [7:0] osc_trim;
  logic [15:0] burst_len;
  logic [11:0] level;
  logic [7:0] trim_hi = 8'h00;
  logic [7:0] trim_lo = 8'h00;
  logic pad;
  logic pad_prev = 1'b1;
  int pulses = 0;
  int miscompares;
  int compares;

  tkbc_top #(.FAST_GAP_CYC(GAP), .LP_SLEEP_CYC(SLEEP), .POWERUP_CYC(100),
    .SHORT_WIN_CYC(3000), .RECAL_MEAS(4)) i_tkbc_top (.clock(clock), .reset_n(reset_n),
    .mode_trigger_pin(mode_trigger_pin), .meas_valid(meas_valid), .meas_count(meas_count),
    .burst_req(burst_req), .detect_out(detect_out), .detect_oe(detect_oe),
    .output_valid(output_valid), .run_mode(run_mode), .osc_trim(osc_trim));

  tkbc_fe_model i_tkbc_fe_model (.clock(clock), .burst_req(burst_req), .burst_len(burst_len),
    .level(level), .meas_valid(meas_valid), .meas_count(meas_count));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // widest trim swing seen over the run
  always @(posedge clock) begin
    if ($signed(osc_trim) > $signed(trim_hi)) trim_hi <= osc_trim;
    if ($signed(osc_trim) < $signed(trim_lo)) trim_lo <= osc_trim;
  end

  // host side pull-up: a released pad reads high, rising edges are counted
  assign pad = detect_oe ? detect_out : 1'b1;

  always @(posedge clock) begin
    pad_prev <= pad;
    if (pad === 1'b1 && pad_prev === 1'b0) pulses <= pulses + 1;
  end

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  // one burst answered with v; returns detect and cycles until the next health window
  task automatic meas(input logic [11:0] v, input int lim, output logic det, output int gap);
    int n;
    level = v;
    n = 0;
    while (meas_valid !== 1'b1) begin
      step;
      n++;
      if (n > 20000) begin
        miscompares++;
        complete_run;
      end
    end
    step;
    det = detect_out;
    gap = 1;
    while (detect_oe !== 1'b0 && gap < lim) begin
      step;
      gap++;
    end
  endtask

  task automatic t_reset;
    `CHK(detect_oe, 1'b1)
    `CHK(output_valid, 1'b0)
    `CHK(run_mode, 2'h0)
    `CHK(burst_req, 1'b0)
    `CHK(detect_out, 1'b0)
    `CHK(osc_trim, 8'h00)
  endtask

  // fast mode: integrator, threshold edge and hysteresis against a reference of 100
  task automatic t_fast;
    logic det;
    int gap;
    int i;
    int n;
    meas(12'h064, 5000, det, gap);
    `CHK(output_valid, 1'b1)
    burst_len = 16'h0014;
    `CHK(gap >= GAP - 2 && gap <= GAP + 4, 1'b1)
    `CHK(trim_hi, 8'h4B)
    `CHK(trim_lo, 8'hB5)
    for (i = 0; i < 3; i++) begin
      meas(12'h06E, 5000, det, gap);
      `CHK(det, 1'b0)
    end
    meas(12'h06D, 5000, det, gap);
    `CHK(det, 1'b0)
    for (i = 0; i < 4; i++) begin
      meas(12'h06E, 5000, det, gap);
      `CHK(det, i == 3)
    end
    n = pulses;
    meas(12'h06C, 5000, det, gap);
    `CHK(det, 1'b1)
    `CHK(pulses - n, 0)
    meas(12'h06B, 5000, det, gap);
    `CHK(det, 1'b0)
    step;
    `CHK(pulses - n, 1)
    meas(12'h06E, 5000, det, gap);
    `CHK(det, 1'b0)
    `CHK(run_mode, 2'h0)
  endtask

  // triggered mode entry, pulse wake, bypassed integrator, then idle fall back to low power
  task automatic t_trig;
    logic det;
    int gap;
    int n;
    @(negedge clock);
    mode_trigger_pin = 1'b0; // held low across the whole next burst
    meas(12'h064, 350, det, gap);
    `CHK(run_mode, 2'h2)
    `CHK(gap, 350)
    @(negedge clock);
    mode_trigger_pin = 1'b1;
    n = 0;
    repeat (2600) begin
      @(negedge clock);
      n += !detect_oe;
    end
    `CHK(n, 0)
    mode_trigger_pin = 1'b0;
    n = 0;
    while (detect_oe !== 1'b0 && n < 20) begin
      step;
      n++;
    end
    `CHK(n < 20, 1'b1)
    meas(12'h06E, 20, det, gap);
    `CHK(det, 1'b1)
    meas(12'h064, 5000, det, gap);
    `CHK(det, 1'b0)
    `CHK(run_mode, 2'h1)
    `CHK(gap >= SLEEP - 2 && gap <= SLEEP + 4, 1'b1)
    meas(12'h06E, 5000, det, gap);
    `CHK(gap <= GAP + 4, 1'b1)
    meas(12'h064, 5000, det, gap);
    `CHK(gap >= SLEEP - 2, 1'b1)
  endtask

  initial begin
    reset_n = 1'b0;
    mode_trigger_pin = 1'b1;
    burst_len = 16'h03B6;
    level = 12'h064;
    miscompares = 0;
    compares = 0;
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    t_reset;
    t_fast;
    t_trig;
    complete_run;
  end
endmodule

bind tkbc_top tkbc_chk #(.POWERUP_CYC(POWERUP_CYC)) i_tkbc_chk (.clock(clock),
  .reset_n(reset_n), .meas_valid(meas_valid), .burst_req(burst_req),
  .detect_out(detect_out), .detect_oe(detect_oe), .output_valid(output_valid),
  .run_mode(run_mode), .osc_trim(osc_trim));
